// ===== core/slsc_map.svh
// Register map, field positions, reset values and frame counts of the link control block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SLSC_MAP_SVH
`define SLSC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLSC_ADDR_W          8
`define SLSC_ADDR_CFG        8'h00
`define SLSC_ADDR_STATUS     8'h04
`define SLSC_ADDR_ERRCNT     8'h08

// ----------------------------------------------------------------
// Configuration fields and reset value
// ----------------------------------------------------------------
`define SLSC_CFG_WIDTH_SEL   0
`define SLSC_CFG_FLAG_USE    1
`define SLSC_CFG_BAND0       2
`define SLSC_CFG_BAND1       3
`define SLSC_CFG_LOOPBACK    4
`define SLSC_CFG_REF_METHOD  5
`define SLSC_CFG_DOUBLE      6
`define SLSC_CFG_BITS        7
`define SLSC_CFG_RESET       7'h00

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SLSC_ST_LOW          0
`define SLSC_ST_HIGH         1
`define SLSC_ST_BUSY         2
`define SLSC_ERRCNT_BITS     16

// ----------------------------------------------------------------
// Frame widths and counts
// ----------------------------------------------------------------
`define SLSC_NARROW_BITS     16
`define SLSC_WIDE_BITS       20
`define SLSC_DEBOUNCE_FRAMES 2
`define SLSC_ACQ_FRAMES      128

`endif

// ===== core/slsc_pkg.sv
// Types shared by the link control block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package slsc_pkg;

  // ----------------------------------------------------------------
  // Frame kinds seen on the serial side
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLSC_K_FILL0 = 3'h0,
    SLSC_K_FILL1 = 3'h1,
    SLSC_K_DATA  = 3'h2,
    SLSC_K_CTRL  = 3'h3,
    SLSC_K_ERR   = 3'h4
  } slsc_kind_type;

  // ----------------------------------------------------------------
  // Link control states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLSC_ST_ACQ  = 3'b001,
    SLSC_ST_WAIT = 3'b010,
    SLSC_ST_DATA = 3'b100
  } slsc_state_type;

endpackage

// ===== core/slsc_frm_if.sv
// Frame indication bundle between the controller, its debouncer and its acquisition timer.
// Assumes all parties run on the same clock.
`timescale 1ns/1ps
interface slsc_frm_if;
  import slsc_pkg::*;
  logic          tick;
  slsc_kind_type ind;
  logic          restart;
  logic          conf_valid;
  logic          busy;

  modport ctrl (output tick, output ind, output restart, input conf_valid, input busy);
  modport deb  (input tick, input ind, output conf_valid);
  modport tmr  (input tick, input ind, input restart, output busy);
endinterface

// ===== core/slsc_debounce.sv
// Confirms a frame indication once it repeats on consecutive frames.
// Assumes one tick per received frame.
`timescale 1ns/1ps
`include "slsc_map.svh"
module slsc_debounce #(
  parameter int N = `SLSC_DEBOUNCE_FRAMES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  slsc_frm_if.deb  frm
);
  import slsc_pkg::*;
  localparam int CW = $clog2(N + 1);

  if (N < 2) begin : g_chk
    $error("debounce needs at least two frames");
  end

  slsc_kind_type last_ff, nxt_last;
  logic [CW-1:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_last = last_ff;
    nxt_cnt  = cnt_ff;
    if (frm.tick) begin
      nxt_last = frm.ind;
      if (frm.ind != last_ff) begin
        nxt_cnt = CW'(1);
      end else if (cnt_ff < CW'(N)) begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_ff <= SLSC_K_ERR;
      cnt_ff  <= '0;
    end else begin
      last_ff <= nxt_last;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Nth identical frame confirms
  assign frm.conf_valid = frm.tick && (frm.ind == last_ff) && (cnt_ff >= CW'(N - 1));
endmodule

// ===== core/slsc_acq_timer.sv
// Holds the acquisition state until enough error-free frames have passed.
// Assumes one tick per received frame; restart comes from the controller resets, a missing transmitter lock or an error pair.
`timescale 1ns/1ps
`include "slsc_map.svh"
module slsc_acq_timer #(
  parameter int FRAMES = `SLSC_ACQ_FRAMES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  slsc_frm_if.tmr  frm
);
  import slsc_pkg::*;
  localparam int CW = $clog2(FRAMES + 1);

  if (FRAMES < 1) begin : g_chk
    $error("acquisition timer needs a positive count");
  end

  logic [CW-1:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (frm.restart) begin
      nxt_cnt = '0;
    end else if (frm.tick) begin
      if (frm.ind == SLSC_K_ERR) begin
        nxt_cnt = '0;
      end else if (cnt_ff < CW'(FRAMES)) begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign frm.busy = (cnt_ff < CW'(FRAMES));
endmodule

// ===== core/slsc_link_ctrl.sv
// Link startup control: receive state controller, transmit framing and register port.
// Assumes frame-level serial side: one receive and one transmit frame strobe per frame,
// all inputs synchronous to i_clk.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "slsc_map.svh"
module slsc_link_ctrl #(
  parameter int DW = `SLSC_WIDE_BITS
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  // Controller resets and transmitter lock
  input  wire logic                     i_ctrl_reset_a_n,
  input  wire logic                     i_ctrl_reset_b_n,
  input  wire logic                     i_tx_pll_locked,
  // Register port
  input  wire logic [`SLSC_ADDR_W-1:0]  i_reg_addr,
  input  wire logic [31:0]              i_reg_wdata,
  input  wire logic                     i_reg_we,
  input  wire logic                     i_reg_re,
  output logic      [31:0]              o_reg_rdata,
  // Transmit host side
  input  wire logic                     i_frame_clock_in,
  input  wire logic [DW-1:0]            i_tx_word,
  input  wire logic                     i_tx_flag,
  input  wire logic                     i_tx_data_word_valid_n,
  input  wire logic                     i_tx_ctrl_word_valid_n,
  output logic                          o_tx_ready,
  // Transmit serial side
  output slsc_pkg::slsc_kind_type       o_tx_kind,
  output logic      [DW-1:0]            o_tx_word,
  output logic                          o_tx_flag,
  output logic                          o_tx_valid,
  // Receive serial side
  input  wire logic                     i_rx_frame_valid,
  input  wire slsc_pkg::slsc_kind_type  i_rx_kind,
  input  wire logic [DW-1:0]            i_rx_word,
  input  wire logic                     i_rx_flag,
  output logic                          o_rx_input_loop,
  // Receive host side
  output logic      [DW-1:0]            o_rx_word,
  output logic                          o_rx_flag,
  output logic                          o_data_word_valid_n,
  output logic                          o_ctrl_word_valid_n,
  output logic                          o_rx_error,
  // State and option outputs
  output logic                          o_state_out_high_bit,
  output logic                          o_state_out_low_bit,
  output logic                          o_fill_type_select,
  output logic                          o_data_send_enable,
  output logic                          o_freq_detect_disable,
  output logic                          o_rx_active,
  output logic                          o_rate_band_sel0,
  output logic                          o_rate_band_sel1
);
  import slsc_pkg::*;

  if (DW != `SLSC_WIDE_BITS) begin : g_chk
    $error("frame width must be the wide frame width");
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic [`SLSC_CFG_BITS-1:0]      cfg_ff, nxt_cfg;
  logic [`SLSC_ERRCNT_BITS-1:0]   errcnt_ff, nxt_errcnt;
  logic [31:0]                    rdata_ff, nxt_rdata;
  logic                           width_select;
  logic                           flag_use_select;
  logic                           loopback_select;
  logic                           ref_method;
  logic                           double_frame;

  assign width_select    = cfg_ff[`SLSC_CFG_WIDTH_SEL];
  assign flag_use_select = cfg_ff[`SLSC_CFG_FLAG_USE];
  assign loopback_select = cfg_ff[`SLSC_CFG_LOOPBACK];
  assign ref_method      = cfg_ff[`SLSC_CFG_REF_METHOD];
  assign double_frame    = cfg_ff[`SLSC_CFG_DOUBLE];

  // ----------------------------------------------------------------
  // Receive frame checking
  // ----------------------------------------------------------------
  slsc_frm_if      frm ();
  slsc_state_type  state_ff, nxt_state;
  logic            prev_flag_ff, nxt_prev_flag;
  logic            held;
  logic            flag_check;
  logic            rx_err;
  logic            err_pair;
  logic [DW-1:0]   wmask;

  assign held       = !i_ctrl_reset_a_n || !i_ctrl_reset_b_n || !i_tx_pll_locked;
  assign flag_check = !flag_use_select && !double_frame;
  assign rx_err     = i_rx_frame_valid && ((i_rx_kind == SLSC_K_ERR) ||
                      (flag_check && (i_rx_flag == prev_flag_ff)));
  assign wmask      = width_select ? '1 : DW'({`SLSC_NARROW_BITS{1'b1}});

  assign frm.tick    = i_rx_frame_valid;
  assign frm.ind     = rx_err ? SLSC_K_ERR : i_rx_kind;
  assign err_pair    = frm.conf_valid && (frm.ind == SLSC_K_ERR);
  assign frm.restart = held || err_pair;

  slsc_debounce #(.N(`SLSC_DEBOUNCE_FRAMES)) u_debounce (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .frm      (frm.deb)
  );

  slsc_acq_timer #(.FRAMES(`SLSC_ACQ_FRAMES)) u_acq_timer (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .frm      (frm.tmr)
  );

  // ----------------------------------------------------------------
  // State controller
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_prev_flag = prev_flag_ff;
    if (i_rx_frame_valid) begin
      nxt_prev_flag = i_rx_flag;
    end
    if (held) begin
      nxt_state = SLSC_ST_ACQ;
    end else if (err_pair) begin
      nxt_state = SLSC_ST_ACQ;
    end else begin
      case (state_ff)
        SLSC_ST_ACQ: begin
          if (frm.conf_valid && !frm.busy &&
              (frm.ind == SLSC_K_FILL0 || frm.ind == SLSC_K_FILL1)) begin
            nxt_state = SLSC_ST_WAIT;
          end
        end
        SLSC_ST_WAIT: begin
          if (frm.conf_valid && frm.ind == SLSC_K_FILL1) begin
            nxt_state = SLSC_ST_DATA;
          end
        end
        SLSC_ST_DATA: begin
          nxt_state = SLSC_ST_DATA;
        end
        default: begin
          nxt_state = SLSC_ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff     <= SLSC_ST_ACQ;
      prev_flag_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      prev_flag_ff <= nxt_prev_flag;
    end
  end

  assign o_state_out_high_bit  = (state_ff != SLSC_ST_ACQ);
  assign o_state_out_low_bit   = (state_ff == SLSC_ST_DATA);
  assign o_fill_type_select    = o_state_out_high_bit;
  assign o_freq_detect_disable = o_state_out_high_bit;
  assign o_rx_active           = o_state_out_high_bit;
  assign o_data_send_enable    = o_state_out_low_bit;
  assign o_tx_ready            = o_data_send_enable;
  assign o_rx_input_loop       = ref_method ? o_state_out_high_bit : loopback_select;
  assign o_rate_band_sel0      = cfg_ff[`SLSC_CFG_BAND0];
  assign o_rate_band_sel1      = cfg_ff[`SLSC_CFG_BAND1];

  // ----------------------------------------------------------------
  // Receive host output
  // ----------------------------------------------------------------
  logic [DW-1:0] rx_word_ff, nxt_rx_word;
  logic          rx_flag_ff, nxt_rx_flag;
  logic          dav_n_ff, nxt_dav_n;
  logic          cav_n_ff, nxt_cav_n;
  logic          rx_err_ff;

  always_comb begin
    nxt_rx_word = rx_word_ff;
    nxt_rx_flag = rx_flag_ff;
    nxt_dav_n   = 1'b1;
    nxt_cav_n   = 1'b1;
    if (i_rx_frame_valid && o_rx_active && !rx_err &&
        (i_rx_kind == SLSC_K_DATA || i_rx_kind == SLSC_K_CTRL)) begin
      nxt_rx_word = i_rx_word & wmask;
      nxt_rx_flag = i_rx_flag;
      nxt_dav_n   = (i_rx_kind != SLSC_K_DATA);
      nxt_cav_n   = (i_rx_kind != SLSC_K_CTRL);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_word_ff <= '0;
      rx_flag_ff <= 1'b0;
      dav_n_ff   <= 1'b1;
      cav_n_ff   <= 1'b1;
      rx_err_ff  <= 1'b0;
    end else begin
      rx_word_ff <= nxt_rx_word;
      rx_flag_ff <= nxt_rx_flag;
      dav_n_ff   <= nxt_dav_n;
      cav_n_ff   <= nxt_cav_n;
      rx_err_ff  <= rx_err;
    end
  end

  assign o_rx_word           = rx_word_ff;
  assign o_rx_flag           = rx_flag_ff;
  assign o_data_word_valid_n = dav_n_ff;
  assign o_ctrl_word_valid_n = cav_n_ff;
  assign o_rx_error          = rx_err_ff;

  // ----------------------------------------------------------------
  // Transmit framing
  // ----------------------------------------------------------------
  slsc_kind_type tx_kind_ff, nxt_tx_kind;
  logic [DW-1:0] tx_word_ff, nxt_tx_word;
  logic          toggle_ff, nxt_toggle;
  logic          tx_flag_ff, nxt_tx_flag;
  logic          tx_valid_ff;

  always_comb begin
    nxt_tx_kind = tx_kind_ff;
    nxt_tx_word = tx_word_ff;
    nxt_toggle  = toggle_ff;
    nxt_tx_flag = tx_flag_ff;
    if (i_frame_clock_in) begin
      nxt_toggle  = !toggle_ff;
      nxt_tx_flag = flag_use_select ? i_tx_flag : !toggle_ff;
      if (o_data_send_enable && (!i_tx_data_word_valid_n || !i_tx_ctrl_word_valid_n)) begin
        nxt_tx_kind = i_tx_data_word_valid_n ? SLSC_K_CTRL : SLSC_K_DATA;
        nxt_tx_word = i_tx_word & wmask;
      end else begin
        nxt_tx_kind = o_fill_type_select ? SLSC_K_FILL1 : SLSC_K_FILL0;
        nxt_tx_word = '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_kind_ff  <= SLSC_K_FILL0;
      tx_word_ff  <= '0;
      toggle_ff   <= 1'b0;
      tx_flag_ff  <= 1'b0;
      tx_valid_ff <= 1'b0;
    end else begin
      tx_kind_ff  <= nxt_tx_kind;
      tx_word_ff  <= nxt_tx_word;
      toggle_ff   <= nxt_toggle;
      tx_flag_ff  <= nxt_tx_flag;
      tx_valid_ff <= i_frame_clock_in;
    end
  end

  assign o_tx_kind  = tx_kind_ff;
  assign o_tx_word  = tx_word_ff;
  assign o_tx_flag  = tx_flag_ff;
  assign o_tx_valid = tx_valid_ff;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_errcnt = errcnt_ff;
    nxt_rdata  = '0;
    if (i_reg_we && i_reg_addr == `SLSC_ADDR_CFG) begin
      nxt_cfg = i_reg_wdata[`SLSC_CFG_BITS-1:0];
    end
    if (i_reg_we && i_reg_addr == `SLSC_ADDR_ERRCNT) begin
      nxt_errcnt = '0;
    end
    // Error beats clear
    if (rx_err && nxt_errcnt != '1) begin
      nxt_errcnt = nxt_errcnt + `SLSC_ERRCNT_BITS'(1);
    end
    if (i_reg_re) begin
      case (i_reg_addr)
        `SLSC_ADDR_CFG: begin
          nxt_rdata[`SLSC_CFG_BITS-1:0] = cfg_ff;
        end
        `SLSC_ADDR_STATUS: begin
          nxt_rdata[`SLSC_ST_LOW]  = o_state_out_low_bit;
          nxt_rdata[`SLSC_ST_HIGH] = o_state_out_high_bit;
          nxt_rdata[`SLSC_ST_BUSY] = frm.busy;
        end
        `SLSC_ADDR_ERRCNT: begin
          nxt_rdata[`SLSC_ERRCNT_BITS-1:0] = errcnt_ff;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_ff    <= `SLSC_CFG_RESET;
      errcnt_ff <= '0;
      rdata_ff  <= '0;
    end else begin
      cfg_ff    <= nxt_cfg;
      errcnt_ff <= nxt_errcnt;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_hold_acq;
    held |=> (state_ff == SLSC_ST_ACQ) && !o_state_out_high_bit;
  endproperty
  a_hold_acq: assert property (p_hold_acq) else $error("left acquisition while held");

  property p_fill0_acq;
    (i_frame_clock_in && !o_state_out_high_bit) |=> (o_tx_kind == SLSC_K_FILL0) && o_tx_valid;
  endproperty
  a_fill0_acq: assert property (p_fill0_acq) else $error("no fill zero in acquisition");

  property p_wait_bits;
    (state_ff == SLSC_ST_WAIT) |-> o_freq_detect_disable && o_fill_type_select && !o_data_send_enable;
  endproperty
  a_wait_bits: assert property (p_wait_bits) else $error("wait state outputs wrong");

  property p_low_rise;
    $rose(o_state_out_low_bit) |-> $past(frm.conf_valid && frm.ind == SLSC_K_FILL1 && !held);
  endproperty
  a_low_rise: assert property (p_low_rise) else $error("send enable without fill one");

  property p_err_pair;
    (frm.conf_valid && frm.ind == SLSC_K_ERR) |=> !o_state_out_high_bit ##1 !o_state_out_high_bit;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("error pair kept lock");

  property p_ref_input;
    (ref_method && err_pair && !(i_reg_we && i_reg_addr == `SLSC_ADDR_CFG)) |=> !o_rx_input_loop;
  endproperty
  a_ref_input: assert property (p_ref_input) else $error("reference input selection wrong");

  property p_flag_err;
    (i_rx_frame_valid && flag_check && i_rx_flag == prev_flag_ff) |=> o_rx_error && o_data_word_valid_n;
  endproperty
  a_flag_err: assert property (p_flag_err) else $error("flag alternation error missed");

  property p_width16;
    (i_frame_clock_in && !width_select) |=> (o_tx_word[DW-1:`SLSC_NARROW_BITS] == '0);
  endproperty
  a_width16: assert property (p_width16) else $error("narrow frame carries upper bits");

  property p_acq_busy;
    (state_ff == SLSC_ST_ACQ && frm.busy) |=> (state_ff == SLSC_ST_ACQ);
  endproperty
  a_acq_busy: assert property (p_acq_busy) else $error("left acquisition early");

  property p_no_data_disabled;
    (i_frame_clock_in && !o_data_send_enable) |=> (o_tx_kind == SLSC_K_FILL0 || o_tx_kind == SLSC_K_FILL1);
  endproperty
  a_no_data_disabled: assert property (p_no_data_disabled) else $error("data sent while disabled");

  c_reach_wait: cover property ($rose(o_state_out_high_bit));
  c_reach_data: cover property ($rose(o_state_out_low_bit));
  c_drop_lock:  cover property (o_state_out_low_bit ##1 !o_state_out_high_bit);
endmodule

// ===== bench/slsc_remote_tx.sv
// Remote transmitter model: one frame every four clocks, kind set by the state lines, or by the sync pulse in sync mode.
// Assumes the same clock as the block; hold input freezes the flag to force errors.
`timescale 1ns/1ps
module slsc_remote_tx (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_fill_type_select,
  input  wire logic               i_data_send_enable,
  input  wire logic               i_hold_flag,
  input  wire logic               i_sync_mode,
  input  wire logic               i_sync_pulse,
  output logic                    o_frame_valid,
  output slsc_pkg::slsc_kind_type o_kind,
  output logic      [19:0]        o_word,
  output logic                    o_flag
);
  import slsc_pkg::*;
  logic [1:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= 2'h0;
      o_frame_valid <= 1'b0;
      o_kind <= SLSC_K_FILL0;
      o_word <= 20'h0;
      o_flag <= 1'b0;
    end else begin
      // own frame pacing stands in for the far reference
      cnt_ff <= cnt_ff + 2'h1;
      o_frame_valid <= (cnt_ff == 2'h3);
      // Word changes every cycle, never stale
      o_word <= o_word + 20'h1;
      if (cnt_ff == 2'h3) begin
        if (i_sync_mode) begin
          // fill type tied high, enable pulsed for lock
          o_kind <= i_sync_pulse ? SLSC_K_FILL1 : SLSC_K_DATA;
        end else begin
          o_kind <= i_data_send_enable ? SLSC_K_DATA : (i_fill_type_select ? SLSC_K_FILL1 : SLSC_K_FILL0);
        end
        o_flag <= i_hold_flag ? o_flag : ~o_flag;
      end
    end
  end
endmodule

// ===== bench/test_slsc_link_ctrl.sv
// Bench for the link control block: startup, error drop, transmit framing, options.
// Assumes the remote transmitter model closes the loop over the state lines.
`timescale 1ns/1ps
module test_slsc_link_ctrl;
  import slsc_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_ctrl_reset_a_n = 1, i_tx_pll_locked = 0, i_reg_we = 0, i_reg_re = 0;
  logic i_frame_clock_in = 0, i_tx_flag = 0, i_tx_data_word_valid_n = 1, i_tx_ctrl_word_valid_n = 1, hold = 0;
  logic sync_mode = 0, sync_pulse = 0, o_tx_ready, o_rx_flag, o_data_word_valid_n, o_ctrl_word_valid_n;
  logic o_freq_detect_disable, o_rx_active;
  logic [7:0] i_reg_addr = 8'h0;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, rd_v;
  logic [19:0] i_tx_word = 20'h0, o_tx_word, i_rx_word, o_rx_word;
  logic o_tx_valid, o_tx_flag, i_rx_frame_valid, i_rx_flag, o_rx_input_loop, o_rx_error;
  logic o_state_out_high_bit, o_state_out_low_bit, o_fill_type_select, o_data_send_enable;
  logic o_rate_band_sel0, o_rate_band_sel1;
  slsc_kind_type o_tx_kind, i_rx_kind;
  int mismatches = 0, n_checks = 0, errs = 0;

  slsc_link_ctrl i_slsc_link_ctrl (.i_clk, .i_resetn, .i_ctrl_reset_a_n, .i_ctrl_reset_b_n(1'b1), .i_tx_pll_locked,
    .i_reg_addr, .i_reg_wdata, .i_reg_we, .i_reg_re, .o_reg_rdata, .i_frame_clock_in, .i_tx_word, .i_tx_flag,
    .i_tx_data_word_valid_n, .i_tx_ctrl_word_valid_n, .o_tx_ready, .o_tx_kind, .o_tx_word, .o_tx_flag,
    .o_tx_valid, .i_rx_frame_valid, .i_rx_kind, .i_rx_word, .i_rx_flag, .o_rx_input_loop, .o_rx_word,
    .o_rx_flag, .o_data_word_valid_n, .o_ctrl_word_valid_n, .o_rx_error, .o_state_out_high_bit,
    .o_state_out_low_bit, .o_fill_type_select, .o_data_send_enable, .o_freq_detect_disable, .o_rx_active,
    .o_rate_band_sel0, .o_rate_band_sel1);
  slsc_remote_tx i_slsc_remote_tx (.i_clk, .i_resetn, .i_fill_type_select(o_fill_type_select),
    .i_data_send_enable(o_data_send_enable), .i_hold_flag(hold), .i_sync_mode(sync_mode),
    .i_sync_pulse(sync_pulse), .o_frame_valid(i_rx_frame_valid),
    .o_kind(i_rx_kind), .o_word(i_rx_word), .o_flag(i_rx_flag));

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_rx_error === 1'b1) errs++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk) begin i_reg_we <= 1; i_reg_addr <= a; i_reg_wdata <= d; end
    @(posedge i_clk) i_reg_we <= 0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_clk) begin i_reg_re <= 1; i_reg_addr <= a; end
    @(posedge i_clk) i_reg_re <= 0;
    #1 rd_v = o_reg_rdata;
  endtask
  task automatic frames(int n);
    repeat (4 * n) @(posedge i_clk);
    #1;
  endtask
  task automatic tx(logic [19:0] w, logic f, logic c, logic [2:0] k, logic [19:0] ew);
    @(posedge i_clk) begin
      i_frame_clock_in <= 1; i_tx_word <= w; i_tx_flag <= f;
      i_tx_data_word_valid_n <= c; i_tx_ctrl_word_valid_n <= !c;
    end
    @(posedge i_clk) i_frame_clock_in <= 0;
    #1 chk(o_tx_valid, 1);
    chk(o_tx_kind, k);
    chk(o_tx_word, ew);
  endtask
  task automatic err_pair();
    @(posedge i_clk) hold <= 1;
    repeat (8) @(posedge i_clk);
    hold <= 0;
    frames(3);
  endtask
  task automatic rx_chk(logic [19:0] m);
    logic [19:0] w;
    logic        f;
    do @(posedge i_clk); while (i_rx_frame_valid !== 1'b1);
    w = i_rx_word;
    f = i_rx_flag;
    #1 chk(o_data_word_valid_n, 0);
    chk(o_ctrl_word_valid_n, 1);
    chk(o_rx_word, w & m);
    chk(o_rx_flag, f);
    @(posedge i_clk) #1 chk(o_data_word_valid_n, 1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_hold();
    frames(140);
    chk({o_state_out_high_bit, o_state_out_low_bit}, 0);
    chk({o_tx_ready, o_freq_detect_disable, o_rx_active}, 0);
    rd(8'h04); chk(rd_v, 32'h4);
    rd(8'h00); chk(rd_v, 32'h0);
    rd(8'h0c); chk(rd_v, 32'h0);
    tx(20'h12345, 0, 0, SLSC_K_FILL0, 20'h0);
  endtask
  task automatic t_start();
    @(posedge i_clk) i_tx_pll_locked <= 1;
    frames(120); chk(o_state_out_high_bit, 0);
    frames(20); chk(o_state_out_high_bit, 1);
    chk({o_fill_type_select, o_freq_detect_disable, o_rx_active}, 3'h7);
    frames(4); chk(o_state_out_low_bit, 1);
    chk(o_tx_ready, 1);
    rd(8'h04); chk(rd_v, 32'h3);
    tx(20'hfffff, 0, 0, SLSC_K_DATA, 20'h0ffff);
    tx(20'h0beef, 0, 1, SLSC_K_CTRL, 20'h0beef);
    rx_chk(20'h0ffff);
  endtask
  task automatic t_err();
    int e0;
    wr(8'h08, 32'h0);
    e0 = errs;
    err_pair(); chk(o_state_out_high_bit, 0);
    chk(errs - e0, 2);
    rd(8'h08); chk(rd_v, 32'h2);
    frames(140); chk(o_state_out_low_bit, 1);
  endtask
  task automatic t_opt();
    logic fp;
    int   e0;
    wr(8'h00, 32'h1f); chk(o_rx_input_loop, 1);
    chk({o_rate_band_sel1, o_rate_band_sel0}, 3);
    tx(20'habcde, 1, 0, SLSC_K_DATA, 20'habcde);
    chk(o_tx_flag, 1);
    wr(8'h00, 32'h40); e0 = errs;
    tx(20'h0abcd, 0, 0, SLSC_K_DATA, 20'h0abcd);
    fp = o_tx_flag;
    tx(20'h01234, 0, 0, SLSC_K_DATA, 20'h01234);
    chk(o_tx_flag, !fp);
    err_pair(); chk(errs - e0, 0);
    chk(o_state_out_low_bit, 1);
    wr(8'h00, 32'h20); chk(o_rx_input_loop, 1);
    chk(!o_rx_input_loop, 1'b0);
    err_pair(); chk(o_rx_input_loop, 0);
    @(posedge i_clk) i_ctrl_reset_a_n <= 0;
    frames(1); chk(o_rx_input_loop, 0);
    @(posedge i_clk) i_ctrl_reset_a_n <= 1;
  endtask
  task automatic t_sync();
    wr(8'h00, 32'h0);
    @(posedge i_clk) begin sync_mode <= 1; sync_pulse <= 1; end
    frames(140); chk({o_state_out_high_bit, o_state_out_low_bit}, 3);
    chk(o_data_word_valid_n, 1);
    @(posedge i_clk) sync_pulse <= 0;
    frames(8); chk({o_state_out_high_bit, o_state_out_low_bit}, 3);
    rx_chk(20'h0ffff);
    @(posedge i_clk) sync_mode <= 0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1;
    t_hold();
    t_start();
    t_err();
    t_opt();
    t_sync();
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
